/* File: hdl/spr_pkg.sv */
// Shared constants and carrier types for the parameter report block.
package spr_pkg;

  // Command and response type codes.
  localparam logic [7:0]  CMD_GET_PARAMS   = 8'h17;
  localparam logic [7:0]  RSP_GET_PARAMS   = 8'h97;
  // Generic response and reason code: command completed, no error.
  localparam logic [15:0] GEN_RSP_CODE     = 16'h0000;
  localparam logic [15:0] GEN_REASON_CODE  = 16'h0000;

  // Capability limits.
  localparam int          MAC_MAX          = 8;
  localparam int          VLAN_MAX         = 15;
  localparam int          MAC_BYTES        = 6;
  localparam int          VLAN_BYTES       = 2;

  // Byte offsets within the response packet.
  localparam logic [7:0]  OFS_PAYLOAD      = 8'h10;
  localparam logic [7:0]  OFS_MAC          = 8'h30;
  localparam int          HDR_BYTES        = 16;
  localparam int          FIXED_END        = 48;
  localparam int          CSUM_BYTES       = 4;

  // VLAN mode support bit positions.
  localparam int          VMODE_ONLY_BIT   = 0;
  localparam int          VMODE_PLUS_BIT   = 1;
  localparam int          VMODE_ANY_BIT    = 2;

  // Configuration flags bit positions.
  localparam int          CFG_BCAST_BIT    = 0;
  localparam int          CFG_CHAN_BIT     = 1;
  localparam int          CFG_TX_BIT       = 2;
  localparam int          CFG_GMC_BIT      = 3;

  // Output FIFO shape.
  localparam int          FIFO_DEPTH       = 32;

  // Settings programmed by the management controller.
  typedef struct packed {
    logic [31:0] link_settings;
    logic [31:0] bcast_settings;
    logic        bcast_en;
    logic        chan_en;
    logic        tx_en;
    logic        gmc_en;
    logic [7:0]  vlan_mode;
    logic [7:0]  flow_ctl;
    logic [31:0] aen_ctl;
    logic [7:0]  mac_en;
    logic [14:0] vlan_en;
  } spr_params_type;

  // Incoming decoded command.
  typedef struct packed {
    logic [7:0] code;
    logic       chk_ok;
    logic       id_ok;
  } spr_cmd_type;

  // One byte of the outgoing response stream.
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } spr_byte_type;

  localparam int          BYTE_W           = $bits(spr_byte_type);

endpackage

/* File: hdl/spr_fifo.sv */
// Parameterised FIFO with a registered output stage.
`timescale 1ns/1ps
`default_nettype none
module spr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock, reset and enable
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_ff != AW'(0) + (AW+1)'(DEPTH));
  assign push          = in_valid_in && in_ready_out;
  // The output register reloads whenever data is stored and it is empty or being taken.
  assign pop           = (count_ff != '0) && (!out_valid_ff || out_ready_in);
  assign out_valid_out = out_valid_ff;
  assign out_data_out  = out_data_ff;

  always_ff @(posedge ref_clk_in) begin
    if (ce_in && push) begin
      mem_ff[wr_ptr_ff] <= in_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else if (ce_in) begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else if (ce_in) begin
      if (pop) begin
        out_valid_ff <= 1'b1;
        out_data_ff  <= mem_ff[rd_ptr_ff];
      end else if (out_ready_in) begin
        out_valid_ff <= 1'b0;
      end
    end
  end
endmodule // spr_fifo
`default_nettype wire

/* File: hdl/spr_report.sv */
// Capability fields and parameter readback response generator.
`timescale 1ns/1ps
`default_nettype none
module spr_report #(
  parameter int UC_CNT    = 4,
  parameter int MC_CNT    = 2,
  parameter int MX_CNT    = 2,
  parameter int VLAN_CNT  = 15,
  parameter int CHAN_CNT  = 1,
  parameter bit VMODE_PLUS = 1'b1,
  parameter bit VMODE_ANY  = 1'b0
) (
  // Clock, reset and enable
  input  wire logic                     ref_clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     ce_in,
  // Command from the packet engine
  input  wire logic                     cmd_valid_in,
  input  wire spr_pkg::spr_cmd_type     cmd_in,
  output logic                          cmd_ready_out,
  output logic                          cmd_taken_out,
  output logic [7:0]                    rsp_type_out,
  output logic [7:0]                    rsp_len_out,
  // Programmed settings and filter tables
  input  wire spr_pkg::spr_params_type  params_in,
  input  wire logic [7:0][47:0]         mac_table_in,
  input  wire logic [14:0][15:0]        vlan_table_in,
  // Capability report fields
  output logic [31:0]                   cap_counts_out,
  output logic [31:0]                   cap_modes_out,
  // Response byte stream
  output logic                          rsp_valid_out,
  input  wire logic                     rsp_ready_in,
  output spr_pkg::spr_byte_type         rsp_byte_out
);
  import spr_pkg::*;

  function automatic int min_int(input int a, input int b);
    return (a < b) ? a : b;
  endfunction

  // Implemented counts are trimmed to what the report format allows.
  localparam int EFF_UC   = min_int(((UC_CNT == 0) && (MX_CNT == 0)) ?
                                    1 : UC_CNT, MAC_MAX);
  // Without unicast filters one mixed filter is kept back for a unicast MAC.
  localparam int EFF_MC   = min_int(MC_CNT, MAC_MAX - EFF_UC -
                                    ((EFF_UC == 0) ? 1 : 0));
  localparam int EFF_MX   = min_int(MX_CNT,
                                    MAC_MAX - EFF_UC - EFF_MC);
  localparam int EFF_MAC  = EFF_UC + EFF_MC + EFF_MX;
  localparam int EFF_VLAN = min_int(VLAN_CNT, VLAN_MAX);
  localparam int MAC_END  = FIXED_END + MAC_BYTES * EFF_MAC;
  localparam int VLAN_END = MAC_END + VLAN_BYTES * EFF_VLAN;
  localparam int PAD_END  = (VLAN_END + 3) / 4 * 4;
  localparam int PKT_LEN  = PAD_END + CSUM_BYTES;

  typedef enum logic [2:0] {
    SPR_IDLE,
    SPR_FIXED,
    SPR_MAC,
    SPR_VLAN,
    SPR_PAD
  } spr_state_type;

  spr_state_type  state_ff;
  spr_state_type  nxt_state;
  spr_params_type params_ff;
  logic [7:0]     pos_ff;
  logic [7:0]     nxt_pos;
  logic [3:0]     ent_ff;
  logic [2:0]     sub_ff;
  logic           cmd_ready_ff;
  logic           cmd_taken_ff;
  logic [7:0]     rsp_type_ff;
  logic [7:0]     rsp_len_ff;
  logic [31:0]    cap_counts_ff;
  logic [31:0]    cap_modes_ff;
  logic           accept;
  logic           fifo_ready;
  logic           emit;
  spr_byte_type   cur_byte;
  logic [7:0]     rel;
  logic [31:0]    word;
  logic [7:0]     mac_flags;
  logic [14:0]    vlan_flags;

  // Region of the response that a byte offset falls in.
  function automatic spr_state_type region(input logic [7:0] pos);
    if (pos < 8'(FIXED_END)) begin
      return SPR_FIXED;
    end else if (pos < 8'(MAC_END)) begin
      return SPR_MAC;
    end else if (pos < 8'(VLAN_END)) begin
      return SPR_VLAN;
    end else if (pos < 8'(PAD_END)) begin
      return SPR_PAD;
    end
    return SPR_IDLE;
  endfunction

  // Enable bitmaps only show entries that exist.
  function automatic logic [14:0] count_mask(input int n);
    logic [14:0] m;
    m = '0;
    for (int i = 0; i < 15; i++) begin
      m[i] = (i < n);
    end
    return m;
  endfunction

  assign mac_flags  = params_ff.mac_en &
                      8'(count_mask(EFF_MAC));
  assign vlan_flags = params_ff.vlan_en & count_mask(EFF_VLAN);

  // Requests are only taken while idle; engine holds them until taken.
  assign accept = cmd_valid_in && cmd_ready_ff &&
                  (cmd_in.code == CMD_GET_PARAMS) &&
                  cmd_in.chk_ok && cmd_in.id_ok;
  assign emit   = (state_ff != SPR_IDLE) && fifo_ready;

  // Fixed parameter words for bytes 16 to 47, most significant byte first.
  assign rel = pos_ff - OFS_PAYLOAD;
  always_comb begin
    case (rel[4:2])
      3'h0: word = {GEN_RSP_CODE, GEN_REASON_CODE};
      3'h1: word = {8'(EFF_MAC), 16'h0000, mac_flags};
      3'h2: word = {8'(EFF_VLAN), 8'h00, 1'b0, vlan_flags};
      3'h3: word = params_ff.link_settings;
      3'h4: word = params_ff.bcast_settings;
      3'h5: word = {28'h0000000, params_ff.gmc_en, params_ff.tx_en,
                    params_ff.chan_en, params_ff.bcast_en};
      3'h6: word = {params_ff.vlan_mode, params_ff.flow_ctl,
                    16'h0000};
      3'h7: word = params_ff.aen_ctl;
      default: word = 32'h00000000;
    endcase
  end

  always_comb begin
    cur_byte.last = (pos_ff == 8'(PAD_END - 1));
    case (state_ff)
      SPR_FIXED: cur_byte.data = word[8 * (3 - rel[1:0]) +: 8];
      // Entry index already follows unicast, multicast, mixed order.
      SPR_MAC:   cur_byte.data = mac_table_in[ent_ff[2:0]]
                                 [8 * (5 - sub_ff) +: 8];
      SPR_VLAN:  cur_byte.data = vlan_table_in[ent_ff]
                                 [8 * (1 - sub_ff[0]) +: 8];
      SPR_PAD:   cur_byte.data = 8'h00;
      default:   cur_byte.data = 8'h00;
    endcase
  end

  assign nxt_pos   = pos_ff + 8'h01;
  assign nxt_state = cur_byte.last ? SPR_IDLE : region(nxt_pos);

  // Request handling and the walk through the response.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_ff <= SPR_IDLE;
      pos_ff   <= OFS_PAYLOAD;
      ent_ff   <= 4'h0;
      sub_ff   <= 3'h0;
    end else if (ce_in) begin
      if (accept) begin
        state_ff <= SPR_FIXED;
        pos_ff   <= OFS_PAYLOAD;
        ent_ff   <= 4'h0;
        sub_ff   <= 3'h0;
      end else if (emit) begin
        state_ff <= nxt_state;
        pos_ff   <= nxt_pos;
        if (nxt_state != state_ff) begin
          ent_ff <= 4'h0;
          sub_ff <= 3'h0;
        end else if ((state_ff == SPR_MAC && sub_ff == 3'(MAC_BYTES - 1)) ||
                     (state_ff == SPR_VLAN &&
                      sub_ff == 3'(VLAN_BYTES - 1))) begin
          ent_ff <= ent_ff + 4'h1;
          sub_ff <= 3'h0;
        end else begin
          sub_ff <= sub_ff + 3'h1;
        end
      end
    end
  end

  // Settings are captured at acceptance so one response's parameter words are self-consistent; MAC and VLAN entries are read live from the tables.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      params_ff <= '0;
    end else if (ce_in && accept) begin
      params_ff <= params_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cmd_ready_ff <= 1'b0;
      cmd_taken_ff <= 1'b0;
      rsp_type_ff  <= 8'h00;
      rsp_len_ff   <= 8'h00;
    end else if (ce_in) begin
      cmd_taken_ff <= accept;
      cmd_ready_ff <= (state_ff == SPR_IDLE) && !accept &&
                      !(emit && nxt_state != SPR_IDLE);
      if (emit && nxt_state == SPR_IDLE) begin
        cmd_ready_ff <= 1'b1;
      end
      if (accept) begin
        rsp_type_ff <= RSP_GET_PARAMS;
        rsp_len_ff  <= 8'(PKT_LEN);
      end
    end
  end

  // Capability fields are static, but come out of registers.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cap_counts_ff <= 32'h00000000;
      cap_modes_ff  <= 32'h00000000;
    end else if (ce_in) begin
      cap_counts_ff <= {8'(EFF_VLAN), 8'(EFF_MX), 8'(EFF_MC),
                        8'(EFF_UC)};
      cap_modes_ff  <= {16'h0000, 5'h00, 1'(VMODE_ANY), 1'(VMODE_PLUS),
                        1'b1, 8'(CHAN_CNT)};
    end
  end

  spr_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .ce_in         (ce_in),
    .in_valid_in   (emit),
    .in_ready_out  (fifo_ready),
    .in_data_in    (cur_byte),
    .out_valid_out (rsp_valid_out),
    .out_ready_in  (rsp_ready_in),
    .out_data_out  (rsp_byte_out)
  );

  assign cmd_ready_out  = cmd_ready_ff;
  assign cmd_taken_out  = cmd_taken_ff;
  assign rsp_type_out   = rsp_type_ff;
  assign rsp_len_out    = rsp_len_ff;
  assign cap_counts_out = cap_counts_ff;
  assign cap_modes_out  = cap_modes_ff;
endmodule // spr_report
`default_nettype wire

/* File: verif/spr_report_properties.sv */
// Concurrent checks on the parameter report block ports.
`timescale 1ns/1ps
`default_nettype none
module spr_report_properties
  import spr_pkg::*;
#(
  parameter bit VMODE_PLUS = 1'b1,
  parameter bit VMODE_ANY  = 1'b0,
  parameter int CHAN_CNT   = 1
) (
  // Clock and reset
  input wire logic                 ref_clk_in,
  input wire logic                 rst_in,
  input wire logic                 ce_in,
  // Command side
  input wire logic                 cmd_valid_in,
  input wire spr_pkg::spr_cmd_type cmd_in,
  input wire logic                 cmd_ready_out,
  input wire logic                 cmd_taken_out,
  input wire logic [7:0]           rsp_type_out,
  input wire logic [7:0]           rsp_len_out,
  // Capability fields
  input wire logic [31:0]          cap_counts_out,
  input wire logic [31:0]          cap_modes_out,
  // Stream side
  input wire logic                 rsp_valid_out,
  input wire logic                 rsp_ready_in,
  input wire spr_pkg::spr_byte_type rsp_byte_out
);
  import spr_pkg::*;
  logic live_ff;
  wire logic ok = cmd_valid_in && cmd_ready_out && ce_in;
  wire logic good = cmd_in.code == CMD_GET_PARAMS && cmd_in.chk_ok &&
                    cmd_in.id_ok;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Capability fields are only meaningful one edge after reset release.
  always_ff @(posedge ref_clk_in) begin
    live_ff <= ~rst_in;
  end
  vlan_limit_a: assert property (live_ff |->
    cap_counts_out[31:24] <= 8'h0F)
    else $error("vlan filter count above limit");
  uc_present_a: assert property (live_ff |->
    (|cap_counts_out[7:0]) || (|cap_counts_out[23:16]))
    else $error("no unicast capable filter");
  mac_total_a: assert property (live_ff |-> 10'(cap_counts_out[7:0]) +
    10'(cap_counts_out[15:8]) + 10'(cap_counts_out[23:16]) <= 10'h008)
    else $error("mac filter total above limit");
  vmode_bits_a: assert property (live_ff |->
    cap_modes_out[15:8] == {5'h00, VMODE_ANY, VMODE_PLUS, 1'b1})
    else $error("vlan mode support byte wrong");
  chan_count_a: assert property (live_ff |-> cap_modes_out[7:0] ==
    8'(CHAN_CNT) && cap_modes_out[31:16] == 16'h0000)
    else $error("channel count byte wrong");
  accept_a: assert property (ok && good |=> cmd_taken_out &&
    rsp_type_out == RSP_GET_PARAMS && rsp_len_out == 8'h84)
    else $error("readback not answered");
  refuse_a: assert property (ok && !good |=> !cmd_taken_out)
    else $error("bad request was taken");
  busy_after_a: assert property (cmd_taken_out |->
    !cmd_ready_out [*8])
    else $error("ready again before response built");
  stream_hold_a: assert property (rsp_valid_out && !rsp_ready_in &&
    ce_in |=> rsp_valid_out && $stable(rsp_byte_out))
    else $error("stalled byte changed");
  cover property (ok && good);
  cover property (rsp_valid_out && !rsp_ready_in);
  cover property (rsp_valid_out && rsp_ready_in && rsp_byte_out.last);
  cover property (rsp_valid_out && !ce_in);
endmodule // spr_report_properties
bind spr_report spr_report_properties #(.VMODE_PLUS(VMODE_PLUS),
  .VMODE_ANY(VMODE_ANY), .CHAN_CNT(CHAN_CNT)) i_spr_report_properties (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
  .cmd_ready_out(cmd_ready_out), .cmd_taken_out(cmd_taken_out),
  .rsp_type_out(rsp_type_out), .rsp_len_out(rsp_len_out),
  .cap_counts_out(cap_counts_out), .cap_modes_out(cap_modes_out),
  .rsp_valid_out(rsp_valid_out), .rsp_ready_in(rsp_ready_in),
  .rsp_byte_out(rsp_byte_out));
`default_nettype wire

/* File: verif/spr_mgmt_model.sv */
// Management controller model: issues requests and sinks response bytes.
`timescale 1ns/1ps
`default_nettype none
module spr_mgmt_model (
  // Clock
  input  wire logic           ref_clk_in,
  // Request side
  input  wire logic           cmd_ready_in,
  input  wire logic           cmd_taken_in,
  output logic                cmd_valid_out,
  output spr_pkg::spr_cmd_type cmd_out,
  // Response sink
  input  wire logic           stall_in,
  output logic                rsp_ready_out
);
  import spr_pkg::*;
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
  end
  assign rsp_ready_out = ~stall_in;
  // A released request shows inverted bits, so stale values never pass.
  task automatic send(input logic [7:0] code, input logic chk, id,
                      input int lim, output logic taken);
    int n;
    taken = 1'b0;
    n = 0;
    @(posedge ref_clk_in);
    while (cmd_ready_in !== 1'b1) @(posedge ref_clk_in);
    cmd_valid_out <= 1'b1;
    cmd_out <= '{code, chk, id};
    while (!taken && n < lim) begin
      @(posedge ref_clk_in);
      taken = cmd_taken_in;
      n++;
    end
    cmd_valid_out <= 1'b0;
    cmd_out <= spr_cmd_type'(~cmd_out);
  endtask
endmodule // spr_mgmt_model
`default_nettype wire

/* File: verif/test_spr_report.sv */
// Self-checking bench for the parameter report block.
`timescale 1ns/1ps
`default_nettype none
module test_spr_report;
  import spr_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic stall = 1'b0;
  logic cmd_valid_in, cmd_ready_out, cmd_taken_out, rsp_valid_out;
  logic rsp_ready_in;
  logic [7:0] rsp_type_out, rsp_len_out;
  logic [31:0] cap_counts_out, cap_modes_out;
  spr_cmd_type cmd_in;
  spr_params_type params_in = '0;
  logic [7:0][47:0] mac_table_in = '0;
  logic [14:0][15:0] vlan_table_in = '0;
  spr_byte_type rsp_byte_out;
  spr_byte_type got_q[$];
  logic [7:0] exp_q[$];
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  logic tk;
  always #4 ref_clk_in = ~ref_clk_in;
  spr_report i_spr_report (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .ce_in(ce_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
    .cmd_ready_out(cmd_ready_out), .cmd_taken_out(cmd_taken_out),
    .rsp_type_out(rsp_type_out), .rsp_len_out(rsp_len_out),
    .params_in(params_in), .mac_table_in(mac_table_in),
    .vlan_table_in(vlan_table_in), .cap_counts_out(cap_counts_out),
    .cap_modes_out(cap_modes_out), .rsp_valid_out(rsp_valid_out),
    .rsp_ready_in(rsp_ready_in), .rsp_byte_out(rsp_byte_out));
  spr_mgmt_model i_spr_mgmt_model (.ref_clk_in(ref_clk_in),
    .cmd_ready_in(cmd_ready_out), .cmd_taken_in(cmd_taken_out),
    .cmd_valid_out(cmd_valid_in), .cmd_out(cmd_in), .stall_in(stall),
    .rsp_ready_out(rsp_ready_in));
  always @(posedge ref_clk_in) begin
    if (rsp_valid_out && rsp_ready_in && ce_in)
      got_q.push_back(rsp_byte_out);
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t got %0h expected %0h", $time, g, e);
    end
  endtask
  // Fresh settings and tables; seed k keeps each run distinct.
  task automatic setp(input logic [7:0] k);
    params_in <= '{{k, 24'hC0FFEE}, {24'hA5A5A5, k}, k[0], k[1], k[2],
                   k[3], k ^ 8'h3C, k ^ 8'h01, {k, 24'h123456}, k ^ 8'hA5,
                   {k[6:0], 8'h5A}};
    for (int m = 0; m < 8; m++) mac_table_in[m] <= {6{k + 8'(m)}};
    for (int v = 0; v < 15; v++) vlan_table_in[v] <= {k, 8'(v + 8'h40)};
    @(posedge ref_clk_in);
  endtask
  task automatic build;
    logic [31:0] w[8];
    exp_q.delete();
    w[0] = 32'h0000_0000;
    w[1] = {8'h08, 16'h0000, params_in.mac_en};
    w[2] = {8'h0F, 8'h00, 1'b0, params_in.vlan_en};
    w[3] = params_in.link_settings;
    w[4] = params_in.bcast_settings;
    w[5] = {28'h0, params_in.gmc_en, params_in.tx_en, params_in.chan_en,
            params_in.bcast_en};
    w[6] = {params_in.vlan_mode, params_in.flow_ctl, 16'h0000};
    w[7] = params_in.aen_ctl;
    foreach (w[i]) for (int b = 3; b >= 0; b--) exp_q.push_back(w[i][8*b+:8]);
    for (int m = 0; m < 8; m++)
      for (int b = 5; b >= 0; b--) exp_q.push_back(mac_table_in[m][8*b+:8]);
    for (int v = 0; v < 15; v++) begin
      exp_q.push_back(vlan_table_in[v][15:8]);
      exp_q.push_back(vlan_table_in[v][7:0]);
    end
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
  endtask
  task automatic readback(input logic st);
    int n;
    spr_byte_type hold;
    got_q.delete();
    build();
    stall <= st;
    i_spr_mgmt_model.send(CMD_GET_PARAMS, 1'b1, 1'b1, 40, tk);
    chk(tk, 1);
    chk(rsp_type_out, RSP_GET_PARAMS);
    chk(rsp_len_out, 8'h84);
    if (st) begin
      // Long enough for the FIFO to fill and the generator to stall.
      repeat (60) @(posedge ref_clk_in);
      chk(cmd_ready_out, 0);
      stall <= 1'b0;
    end else begin
      // Freeze mid-stream; the byte on offer must hold and none is lost.
      repeat (20) @(posedge ref_clk_in);
      ce_in <= 1'b0;
      @(posedge ref_clk_in);
      hold = rsp_byte_out;
      repeat (6) @(posedge ref_clk_in);
      chk(rsp_byte_out, hold);
      chk(rsp_valid_out, 1);
      chk(cmd_ready_out, 0);
      ce_in <= 1'b1;
    end
    n = 0;
    while (got_q.size() < 112 && n < 400) begin
      @(posedge ref_clk_in);
      n++;
    end
    repeat (3) @(posedge ref_clk_in);
    chk(got_q.size(), 112);
    foreach (got_q[i]) begin
      if (i < 8)
        chk(got_q[i].data, exp_q[i]);
      else if (i < 16)
        chk(got_q[i].data, exp_q[i]);
      else if (i < 32)
        chk(got_q[i].data, exp_q[i]);
      else if (i < 80)
        chk(got_q[i].data, exp_q[i]);
      else
        chk(got_q[i].data, exp_q[i]);
      chk(got_q[i].last, i == 111);
    end
    $display("readback test done");
  endtask
  initial begin
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    chk(cap_counts_out, 32'h0F02_0204);
    chk(cap_modes_out, 32'h0000_0301);
    $display("capability test done");
    i_spr_mgmt_model.send(8'h18, 1'b1, 1'b1, 8, tk);
    chk(tk, 0);
    i_spr_mgmt_model.send(CMD_GET_PARAMS, 1'b0, 1'b1, 8, tk);
    chk(tk, 0);
    i_spr_mgmt_model.send(CMD_GET_PARAMS, 1'b1, 1'b0, 8, tk);
    chk(tk, 0);
    $display("refusal test done");
    setp(8'h3B);
    readback(1'b1);
    setp(8'hC4);
    readback(1'b0);
    final_report();
  end
endmodule // test_spr_report
`default_nettype wire
